// file: src/cmsd_top.sv
// control mode strap decoder: pins in, operating modes out
`timescale 1ns/100ps
`default_nettype none
`include "cmsd_regs.svh"
module cmsd_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic extended_control_strap,
  input wire logic clock_reset_style_select,
  input wire logic full_scale_range_select,
  input wire logic full_scale_range_select_mid,
  input wire logic output_clock_reset_pos,
  input wire logic calibration_running,
  input wire logic fs_adjust_write_req,
  output logic calibration_active_flag,
  output logic extended_mode_active,
  output logic alternate_extended_strap,
  output logic reset_style_differential,
  output logic output_clock_reset,
  output logic full_scale_range_high,
  output logic fs_adjust_write_enable,
  output cmsd_pkg::cmsd_mode_e mode
);
  cmsd_pins_if pins_bus ();
  cmsd_pkg::cmsd_pins_s pin;

  logic next_cal_flag;
  logic next_ext_active;
  logic next_alt_ext;
  logic next_diff;
  logic next_clk_rst;
  logic next_range_high;
  logic next_fs_wr_en;
  cmsd_pkg::cmsd_mode_e next_mode;

  // pins are asynchronous to the input clock, so they are synchronised first
  assign pins_bus.raw = {output_clock_reset_pos, full_scale_range_select_mid,
                         full_scale_range_select, clock_reset_style_select,
                         extended_control_strap};

  cmsd_sync u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .pins(pins_bus.sync_side)
  );

  assign pin = pins_bus.synced;

  function automatic cmsd_pkg::cmsd_mode_e mode_of(input logic ext, input logic diff);
    mode_of = cmsd_pkg::CMSD_MODE_PIN_SE;
    case ({diff, ext})
      2'h0: mode_of = cmsd_pkg::CMSD_MODE_PIN_SE;
      2'h1: mode_of = cmsd_pkg::CMSD_MODE_EXT_SE;
      2'h3: mode_of = cmsd_pkg::CMSD_MODE_EXT_DIFF;
      2'h2: mode_of = cmsd_pkg::CMSD_MODE_PIN_DIFF;
      default: mode_of = cmsd_pkg::CMSD_MODE_PIN_SE;
    endcase
  endfunction

  // purely combinational decode of current pins; nothing latched at reset
  always_comb begin
    next_cal_flag = calibration_running;
    next_diff = !pin.style_sel;
    // alternate enable only exists while the pin is not a reset leg
    next_alt_ext = !next_diff && pin.mf_mid;
    // dedicated strap decides alone; the alternate request cannot overturn it
    next_ext_active = !pin.ext_strap;
    if (next_diff) begin
      next_clk_rst = pin.rst_pos && !pin.mf_level;
      next_range_high = 1'h1;
    end else begin
      next_clk_rst = pin.rst_pos;
      // a mid level reads as neither range; keep the higher default then
      next_range_high = pin.mf_mid ? 1'h1 : pin.mf_level;
    end
    next_fs_wr_en = fs_adjust_write_req && !pin.ext_strap && next_ext_active;
    next_mode = mode_of(next_ext_active, next_diff);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      calibration_active_flag <= `CMSD_RST_LOW_FLAG;
      extended_mode_active <= `CMSD_RST_EXT_ACTIVE;
      alternate_extended_strap <= `CMSD_RST_LOW_FLAG;
      reset_style_differential <= `CMSD_RST_DIFF_STYLE;
      output_clock_reset <= `CMSD_RST_LOW_FLAG;
      full_scale_range_high <= `CMSD_RST_RANGE_HIGH;
      fs_adjust_write_enable <= `CMSD_RST_LOW_FLAG;
      mode <= cmsd_pkg::CMSD_MODE_PIN_SE;
    end else begin
      calibration_active_flag <= next_cal_flag;
      extended_mode_active <= next_ext_active;
      alternate_extended_strap <= next_alt_ext;
      reset_style_differential <= next_diff;
      output_clock_reset <= next_clk_rst;
      full_scale_range_high <= next_range_high;
      fs_adjust_write_enable <= next_fs_wr_en;
      mode <= next_mode;
    end
  end
endmodule
`default_nettype wire

// file: src/cmsd_regs.svh
// constants for the control mode strap decoder
`ifndef CMSD_REGS_SVH
`define CMSD_REGS_SVH
`define CMSD_PIN_COUNT 5
`define CMSD_BIT_EXT_STRAP 0
`define CMSD_BIT_STYLE_SEL 1
`define CMSD_BIT_MF_LEVEL 2
`define CMSD_BIT_MF_MID 3
`define CMSD_BIT_RST_POS 4
`define CMSD_SYNC_STAGES 2
`define CMSD_RST_SYNC_PINS 5'h03
`define CMSD_RST_EXT_ACTIVE 1'h0
`define CMSD_RST_DIFF_STYLE 1'h0
`define CMSD_RST_RANGE_HIGH 1'h1
`define CMSD_RST_LOW_FLAG 1'h0
`endif

// file: src/cmsd_pkg.sv
// types for the control mode strap decoder
package cmsd_pkg;
  typedef enum logic [1:0] {
    CMSD_MODE_PIN_SE = 2'h0,
    CMSD_MODE_EXT_SE = 2'h1,
    CMSD_MODE_EXT_DIFF = 2'h3,
    CMSD_MODE_PIN_DIFF = 2'h2
  } cmsd_mode_e;
  typedef struct packed {
    logic rst_pos;
    logic mf_mid;
    logic mf_level;
    logic style_sel;
    logic ext_strap;
  } cmsd_pins_s;
endpackage

// file: src/cmsd_pins_if.sv
// carrier between the pin synchroniser and the decoder
`timescale 1ns/100ps
`default_nettype none
interface cmsd_pins_if;
  cmsd_pkg::cmsd_pins_s raw;
  cmsd_pkg::cmsd_pins_s synced;
  modport sync_side (input raw, output synced);
  modport core_side (output raw, input synced);
endinterface
`default_nettype wire

// file: src/cmsd_sync.sv
// two-flop synchroniser for the static control pins
`timescale 1ns/100ps
`default_nettype none
`include "cmsd_regs.svh"
module cmsd_sync (
  input wire logic clock,
  input wire logic rst_n,
  cmsd_pins_if.sync_side pins
);
  cmsd_pkg::cmsd_pins_s meta;
  cmsd_pkg::cmsd_pins_s stable;
  cmsd_pkg::cmsd_pins_s next_meta;
  cmsd_pkg::cmsd_pins_s next_stable;

  // first stage is read only by the second stage
  always_comb begin
    next_meta = pins.raw;
    next_stable = meta;
  end

  // reset to the strap-high, single-ended, pin-mode picture
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta <= `CMSD_RST_SYNC_PINS;
      stable <= `CMSD_RST_SYNC_PINS;
    end else begin
      meta <= next_meta;
      stable <= next_stable;
    end
  end

  assign pins.synced = stable;
endmodule
`default_nettype wire

// file: tb/cmsd_top_checker.sv
// assertions on the strap decoder ports
`timescale 1ns/100ps
`default_nettype none
module cmsd_top_checker (
  input wire logic clock, rst_n, extended_control_strap, clock_reset_style_select,
  input wire logic full_scale_range_select, full_scale_range_select_mid, output_clock_reset_pos,
  input wire logic calibration_running, fs_adjust_write_req, calibration_active_flag,
  input wire logic extended_mode_active, alternate_extended_strap, reset_style_differential,
  input wire logic output_clock_reset, full_scale_range_high, fs_adjust_write_enable,
  input wire cmsd_pkg::cmsd_mode_e mode
);
  // delayed pin copies; top bit stays low until the pipe has refilled after reset
  logic [7:0] d1, d2, d3;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) {d1, d2, d3} <= 24'h0;
    else {d1, d2, d3} <= {1'h1, calibration_running, fs_adjust_write_req, extended_control_strap,
      clock_reset_style_select, full_scale_range_select, full_scale_range_select_mid,
      output_clock_reset_pos, d1, d2};
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n || !d3[7]);
  property p_cal; calibration_active_flag == d1[6]; endproperty
  a_cal: assert property (p_cal) else $error("cal");
  property p_ext; extended_mode_active == !d3[4]; endproperty
  a_ext: assert property (p_ext) else $error("ext");
  property p_ocr; output_clock_reset == (d3[0] && !(reset_style_differential && d3[2])); endproperty
  a_ocr: assert property (p_ocr) else $error("ocr");
  property p_fsr; reset_style_differential |-> full_scale_range_high; endproperty
  a_fsr: assert property (p_fsr) else $error("fsr");
  property p_rng; d3[3] && !d3[1] |-> full_scale_range_high == d3[2]; endproperty
  a_rng: assert property (p_rng) else $error("rng");
  property p_alt; alternate_extended_strap == (d3[3] && d3[1]); endproperty
  a_alt: assert property (p_alt) else $error("alt");
  property p_wr; fs_adjust_write_enable == (d1[5] && extended_mode_active); endproperty
  a_wr: assert property (p_wr) else $error("wr");
  property p_mode; mode == {!d3[3], !d3[4]}; endproperty
  a_mode: assert property (p_mode) else $error("mode");
  c_alt: cover property (alternate_extended_strap);
  c_dif: cover property (reset_style_differential && fs_adjust_write_enable);
  c_cal: cover property (calibration_active_flag);
endmodule
`default_nettype wire

// file: tb/cmsd_straps.sv
// board strap model driving the decoder pins
`timescale 1ns/100ps
`default_nettype none
module cmsd_straps (
  input wire logic clock,
  input wire logic [4:0] set,
  output logic [4:0] pins
);
  logic tog = 1'h0;
  always @(negedge clock) tog <= !tog;
  // a floating pin has no trustworthy level, so it reads as noise
  assign pins = {set[4:3], set[1] ? tog : set[2], set[1:0]};
endmodule
`default_nettype wire

// file: tb/tb_cmsd_top.sv
// self-checking bench for the control mode strap decoder
`timescale 1ns/100ps
`default_nettype none
module tb_cmsd_top;
  logic clock = 1'h0, rst_n = 1'h0, calibration_running = 1'h0, fs_adjust_write_req = 1'h0;
  logic extended_control_strap, clock_reset_style_select, full_scale_range_select;
  logic full_scale_range_select_mid, output_clock_reset_pos, calibration_active_flag;
  logic extended_mode_active, alternate_extended_strap, reset_style_differential;
  logic output_clock_reset, full_scale_range_high, fs_adjust_write_enable;
  cmsd_pkg::cmsd_mode_e mode;
  logic [4:0] set = 5'h18;
  int fail_count = 0, checks = 0;
  always #5 clock = !clock;
  cmsd_straps u_straps (.clock(clock), .set(set), .pins({extended_control_strap,
    clock_reset_style_select, full_scale_range_select, full_scale_range_select_mid,
    output_clock_reset_pos}));
  cmsd_top DUT (.*);
  task automatic chk(string n, logic [8:0] e, logic [8:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic step(string n, logic [4:0] s, logic [8:0] e);
    @(negedge clock);
    set = s;
    repeat (4) @(negedge clock);
    chk(n, e, {calibration_active_flag, fs_adjust_write_enable, extended_mode_active,
      alternate_extended_strap, reset_style_differential, output_clock_reset,
      full_scale_range_high, mode});
    $display("test %s done", n);
  endtask
  task automatic t_cal();
    calibration_running = 1'h1;
    @(negedge clock);
    chk("cal_on", 9'h100, {calibration_active_flag, 8'h00});
    calibration_running = 1'h0;
    @(negedge clock);
    chk("cal_off", 9'h000, {calibration_active_flag, 8'h00});
    $display("test cal done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1'h1;
    fs_adjust_write_req = 1'h1;
    step("pin_low", 5'h19, 9'h008);
    step("pin_high", 5'h1c, 9'h004);
    step("alt_overridden", 5'h1a, 9'h024);
    step("ext_se", 5'h0a, 9'h0e5);
    step("diff_pin", 5'h11, 9'h01e);
    step("diff_ext", 5'h05, 9'h0d7);
    t_cal();
    test_done();
  end
  initial begin
    #2000;
    fail_count++;
    test_done();
  end
endmodule
bind cmsd_top cmsd_top_checker u_chk (.*);
`default_nettype wire
